// ===== core/vjss_stage.sv
// Vector jump supervision stage: angle change, pick-up gating, events, counters, history.
// Assumes PROG_TICK, BLOCK_IN and all settings come from logic on the same clock.
`timescale 1ns/100ps

// Function
// - Status output is normal, blocked, trip or alarm.
// - Report whether the monitored channel selection is valid.
// - Per channel angle change over 20 ms, signed, 0.01 deg.
// - Per channel ratio of voltage to undervoltage limit, 0.01 p.u.
// - Sample the block input once at each processing cycle start.
// - Unblocked pick-up asserts trip or alarm and proceeds to timing.
// - Blocked pick-up asserts blocked and goes no further.
// - Separate ON and OFF events for block, trip and alarm.
// - Per-event selection decides which events reach the event buffer.
// - Every recorded event carries a time stamp.
// - Resettable cumulative counters for alarm, trip and blocked.
// - Keep the twelve most recent time-stamped history entries.
// - History written only on ON of alarm, trip or blocked.
// - Entry holds time, event, fault type, angle differences, group.
// - Trip stays asserted 20 ms then clears by itself.
// - Stage is blocked while measured voltage is below limit.
// - Static setting selects trip only or trip with alarm.
module vjss_stage #(
  parameter int TRIP_CYCLES = vjss_pkg::TRIP_HOLD_CYCLES,  // Trip pulse in clocks
  parameter int SPAN = vjss_pkg::SPAN_TICKS                // Program cycles per 20 ms
) (
  input wire logic CLK,                                  // 20 MHz clock
  input wire logic RST,                                  // Async reset, active high
  input wire logic PROG_TICK,                            // Program cycle start pulse
  input wire logic BLOCK_IN,                             // Block from blocking matrix
  input wire vjss_pkg::vjss_meas_type MEAS,              // Channel angles and magnitudes
  input wire logic [vjss_pkg::NCH-1:0] CHAN_AVAIL,       // Channels present in the VT setup
  input wire vjss_pkg::vjss_set_type SETTINGS,           // Stage settings
  input wire logic [vjss_pkg::EV_N-1:0] EVT_MASK,        // Events to store
  input wire logic [vjss_pkg::TS_W-1:0] TIME_MS,         // Relay time in ms
  input wire logic CNT_CLR,                              // Counter reset request
  input wire logic [vjss_pkg::HPTR_W-1:0] HIST_IDX,      // History entry, 0 newest
  output vjss_pkg::vjss_status_type STATUS,              // Stage status
  output logic SEL_OK,                                   // Channel selection valid
  output logic [vjss_pkg::NCH-1:0][vjss_pkg::DIFF_W-1:0] ANGLE_CHANGE, // Signed changes
  output logic [vjss_pkg::NCH-1:0][vjss_pkg::RAT_W-1:0] VOLT_RATIO,    // Ratios
  output logic TRIP_OUT,                                 // Trip output
  output logic ALARM_OUT,                                // Alarm output
  output logic BLOCKED_OUT,                              // Blocked indication
  output logic EVT_VALID,                                // Event pulse
  output logic [vjss_pkg::EV_N-1:0] EVT_VEC,             // Stored event kinds
  output logic [vjss_pkg::TS_W-1:0] EVT_STAMP,           // Event time stamp
  output logic [vjss_pkg::CNT_W-1:0] CNT_ALARM,          // Alarm count
  output logic [vjss_pkg::CNT_W-1:0] CNT_TRIP,           // Trip count
  output logic [vjss_pkg::CNT_W-1:0] CNT_BLOCK,          // Blocked count
  output vjss_pkg::vjss_hist_type HIST_DATA,             // Selected history entry
  output logic [vjss_pkg::HPTR_W-1:0] HIST_COUNT         // Valid history entries
);
  import vjss_pkg::*;

  localparam int TW = $clog2(TRIP_CYCLES + 1);

  // ==========================================================================
  // Elaboration checks
  if (TRIP_CYCLES < 1 || TRIP_CYCLES > (1 << 24)) begin : g_trip_chk
    $error("TRIP_CYCLES out of range");
  end
  if (SPAN < 2) begin : g_span_chk
    $error("SPAN must be at least 2");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    logic [SPAN-1:0][NCH-1:0][ANG_W-1:0] ang_hist;  // Oldest at SPAN-1
    logic [NCH-1:0][DIFF_W-1:0] diff;
    logic [NCH-1:0][RAT_W-1:0] ratio;
    vjss_status_type status;
    logic sel_ok;
    logic trip;
    logic alarm;
    logic blocked;
    logic [TW-1:0] trip_timer;
    logic evt_valid;
    logic [EV_N-1:0] evt_vec;
    logic [TS_W-1:0] evt_stamp;
    logic [CNT_W-1:0] cnt_alarm;
    logic [CNT_W-1:0] cnt_trip;
    logic [CNT_W-1:0] cnt_block;
    logic [HIST_N-1:0][$bits(vjss_hist_type)-1:0] hist;
    logic [HPTR_W-1:0] wr_ptr;
    logic [HPTR_W-1:0] hist_count;
    vjss_hist_type hist_data;
  } vjss_state_type;

  vjss_state_type s;
  vjss_state_type next_s;
  logic trip_pu;
  logic alarm_pu;
  logic uv;

  // Magnitude of a signed angle change
  function automatic logic [DIFF_W-1:0] abs_diff(input logic [DIFF_W-1:0] d);
    abs_diff = d[DIFF_W-1] ? DIFF_W'(-$signed(d)) : d;
  endfunction

  // Ratio in 0.01 p.u., saturating; a zero limit reads as full scale
  function automatic logic [RAT_W-1:0] volt_ratio(input logic [MAG_W-1:0] mag,
                                                  input logic [MAG_W-1:0] lim);
    logic [MAG_W+6:0] q;
    q = '1;
    if (lim != '0) begin
      q = ((MAG_W+7)'(mag) * (MAG_W+7)'(RATIO_SCALE)) / (MAG_W+7)'(lim);
    end
    volt_ratio = (q > (MAG_W+7)'({RAT_W{1'b1}})) ? '1 : q[RAT_W-1:0];
  endfunction

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic [EV_N-1:0] ev;
    logic [1:0] fault;
    logic [DIFF_W-1:0] fdiff;
    logic found;
    logic [HPTR_W:0] rd;
    vjss_hist_type entry;
    next_s = s;
    ev = '0;
    fault = '0;
    fdiff = '0;
    found = 1'b0;
    rd = '0;
    entry = '0;
    trip_pu = 1'b0;
    alarm_pu = 1'b0;
    uv = 1'b0;
    next_s.evt_valid = 1'b0;
    next_s.evt_vec = '0;
    // Pick-up evaluation from the present sample and the one a span ago
    for (int ch = 0; ch < NCH; ch++) begin
      logic [DIFF_W-1:0] d;
      d = DIFF_W'($signed(MEAS.angle[ch]) - $signed(s.ang_hist[SPAN-1][ch]));
      if (SETTINGS.chan_sel[ch] && s.sel_ok) begin
        if (abs_diff(d) >= DIFF_W'(SETTINGS.trip_pickup)) begin
          trip_pu = 1'b1;
        end
        if (abs_diff(d) >= DIFF_W'(SETTINGS.alarm_pickup) && SETTINGS.alarm_en) begin
          alarm_pu = 1'b1;
        end
        if (MEAS.mag[ch] < SETTINGS.uv_limit) begin
          uv = 1'b1;
        end
        if (!found && (abs_diff(d) >= DIFF_W'(SETTINGS.trip_pickup) ||
                       MEAS.mag[ch] < SETTINGS.uv_limit)) begin
          found = 1'b1;
          fault = 2'(ch);
          fdiff = d;
        end
      end
    end
    // Trip pulse times out by itself, independent of later pick-ups
    if (s.trip) begin
      if (s.trip_timer == '0) begin
        next_s.trip = 1'b0;
      end else begin
        next_s.trip_timer = s.trip_timer - 1'b1;
      end
    end
    // Block input is looked at only here, once per program cycle; its source
    // must lead the operating delay by the documented margin
    if (PROG_TICK) begin
      next_s.ang_hist = {s.ang_hist[SPAN-2:0], MEAS.angle};
      for (int ch = 0; ch < NCH; ch++) begin
        next_s.diff[ch] = DIFF_W'($signed(MEAS.angle[ch]) - $signed(s.ang_hist[SPAN-1][ch]));
        next_s.ratio[ch] = volt_ratio(MEAS.mag[ch], SETTINGS.uv_limit);
      end
      next_s.sel_ok = (SETTINGS.chan_sel != '0) &&
                      ((SETTINGS.chan_sel & ~CHAN_AVAIL) == '0);
      if (uv || (BLOCK_IN && (trip_pu || alarm_pu))) begin
        next_s.blocked = 1'b1;
        next_s.alarm = 1'b0;
      end else begin
        next_s.blocked = 1'b0;
        next_s.alarm = alarm_pu;
        if (trip_pu && !s.trip) begin
          next_s.trip = 1'b1;
          next_s.trip_timer = TW'(TRIP_CYCLES - 1);
        end
      end
    end
    // Status priority: trip, alarm, blocked, normal
    next_s.status = next_s.trip ? ST_TRIP : next_s.alarm ? ST_ALARM :
                    next_s.blocked ? ST_BLOCKED : ST_NORMAL;
    // Edge events
    ev[EV_BLOCK_ON] = next_s.blocked & ~s.blocked;
    ev[EV_BLOCK_OFF] = ~next_s.blocked & s.blocked;
    ev[EV_TRIP_ON] = next_s.trip & ~s.trip;
    ev[EV_TRIP_OFF] = ~next_s.trip & s.trip;
    ev[EV_ALARM_ON] = next_s.alarm & ~s.alarm;
    ev[EV_ALARM_OFF] = ~next_s.alarm & s.alarm;
    next_s.evt_vec = ev & EVT_MASK;
    next_s.evt_valid = |(ev & EVT_MASK);
    if (|(ev & EVT_MASK)) begin
      next_s.evt_stamp = TIME_MS;
    end
    // Counters; an event in the clearing cycle still counts once
    next_s.cnt_alarm = s.cnt_alarm + CNT_W'(ev[EV_ALARM_ON]);
    next_s.cnt_trip = s.cnt_trip + CNT_W'(ev[EV_TRIP_ON]);
    next_s.cnt_block = s.cnt_block + CNT_W'(ev[EV_BLOCK_ON]);
    if (CNT_CLR) begin
      next_s.cnt_alarm = CNT_W'(ev[EV_ALARM_ON]);
      next_s.cnt_trip = CNT_W'(ev[EV_TRIP_ON]);
      next_s.cnt_block = CNT_W'(ev[EV_BLOCK_ON]);
    end
    // History entry on any ON edge; one entry per cycle, trip named first
    if (ev[EV_TRIP_ON] || ev[EV_ALARM_ON] || ev[EV_BLOCK_ON]) begin
      entry.stamp = TIME_MS;
      entry.name = ev[EV_TRIP_ON] ? EVN_TRIP : ev[EV_ALARM_ON] ? EVN_ALARM : EVN_BLOCK;
      entry.fault = fault;
      entry.trip_diff = next_s.trip ? fdiff : '0;
      entry.alarm_diff = next_s.alarm ? fdiff : '0;
      entry.group = SETTINGS.group;
      next_s.hist[s.wr_ptr] = entry;
      next_s.wr_ptr = (s.wr_ptr == HPTR_W'(HIST_N - 1)) ? '0 : s.wr_ptr + 1'b1;
      if (s.hist_count != HPTR_W'(HIST_N)) begin
        next_s.hist_count = s.hist_count + 1'b1;
      end
    end
    // Read port, index 0 is the newest entry
    rd = (HPTR_W+1)'(s.wr_ptr) + (HPTR_W+1)'(HIST_N - 1) - (HPTR_W+1)'(HIST_IDX);
    if (rd >= (HPTR_W+1)'(HIST_N)) begin
      rd = rd - (HPTR_W+1)'(HIST_N);
    end
    next_s.hist_data = (HIST_IDX < s.hist_count && rd < (HPTR_W+1)'(HIST_N)) ?
                       vjss_hist_type'(s.hist[rd[HPTR_W-1:0]]) : '0;
  end

  // State register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  assign STATUS = s.status;
  assign SEL_OK = s.sel_ok;
  assign ANGLE_CHANGE = s.diff;
  assign VOLT_RATIO = s.ratio;
  assign TRIP_OUT = s.trip;
  assign ALARM_OUT = s.alarm;
  assign BLOCKED_OUT = s.blocked;
  assign EVT_VALID = s.evt_valid;
  assign EVT_VEC = s.evt_vec;
  assign EVT_STAMP = s.evt_stamp;
  assign CNT_ALARM = s.cnt_alarm;
  assign CNT_TRIP = s.cnt_trip;
  assign CNT_BLOCK = s.cnt_block;
  assign HIST_DATA = s.hist_data;
  assign HIST_COUNT = s.hist_count;

  // ==========================================================================
  // Assertions
  int trip_run;

  // Length of the present trip pulse, for the hold check
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      trip_run <= 0;
    end else begin
      trip_run <= TRIP_OUT ? trip_run + 1 : 0;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  status_code_a: assert property (STATUS == (TRIP_OUT ? ST_TRIP : ALARM_OUT ? ST_ALARM :
    BLOCKED_OUT ? ST_BLOCKED : ST_NORMAL)) else $error("status code mismatch");
  sel_valid_a: assert property (PROG_TICK |=> SEL_OK == ($past(SETTINGS.chan_sel) != '0 &&
    ($past(SETTINGS.chan_sel) & ~$past(CHAN_AVAIL)) == '0)) else $error("selection flag wrong");
  angle_span_a: assert property (PROG_TICK |=> ANGLE_CHANGE[0] ==
    DIFF_W'($signed($past(MEAS.angle[0])) - $signed($past(s.ang_hist[SPAN-1][0]))))
    else $error("angle change wrong");
  trip_hold_a: assert property ($fell(TRIP_OUT) |-> trip_run == TRIP_CYCLES)
    else $error("trip pulse length wrong");
  trip_start_a: assert property (PROG_TICK && !BLOCK_IN && !uv && trip_pu && !TRIP_OUT
    |=> TRIP_OUT) else $error("trip did not start");
  block_gate_a: assert property (PROG_TICK && BLOCK_IN && (trip_pu || alarm_pu)
    |=> BLOCKED_OUT && !$rose(TRIP_OUT) && !ALARM_OUT) else $error("blocked pick-up went on");
  uv_block_a: assert property (PROG_TICK && uv |=> BLOCKED_OUT)
    else $error("undervoltage did not block");
  cnt_clear_a: assert property (CNT_CLR |=> CNT_TRIP == CNT_W'($rose(TRIP_OUT)) &&
    CNT_ALARM == CNT_W'($rose(ALARM_OUT))) else $error("counter clear wrong");
  trip_event_a: assert property ($rose(TRIP_OUT) && $past(EVT_MASK[EV_TRIP_ON]) |->
    EVT_VALID && EVT_VEC[EV_TRIP_ON] && EVT_STAMP == $past(TIME_MS))
    else $error("trip event missing");
  evt_filter_a: assert property (EVT_VALID |-> (EVT_VEC & ~$past(EVT_MASK)) == '0)
    else $error("unselected event stored");
  hist_write_a: assert property ($rose(BLOCKED_OUT) && $past(HIST_COUNT) < HPTR_W'(HIST_N)
    |-> HIST_COUNT == $past(HIST_COUNT) + 1'b1) else $error("history not written");
  hist_bound_a: assert property (HIST_COUNT <= HPTR_W'(HIST_N))
    else $error("history count overflow");

  trip_seen_c: cover property ($rose(TRIP_OUT));
  blocked_seen_c: cover property (PROG_TICK && BLOCK_IN && trip_pu ##1 BLOCKED_OUT);
  alarm_seen_c: cover property ($rose(ALARM_OUT));
  hist_full_c: cover property ($rose(BLOCKED_OUT) && HIST_COUNT == HPTR_W'(HIST_N));
endmodule // vjss_stage

// ===== core/vjss_pkg.sv
// Constants, field layouts and carrier types of the vector jump supervision stage.
// Assumes one 20 MHz clock and a program-cycle tick produced by the relay sequencer.
package vjss_pkg;
  // ==========================================================================
  // Widths and sizes
  localparam int NCH = 3;            // Monitored voltage channels
  localparam int ANG_W = 16;         // Phase angle, 0.01 deg units, -180..180 deg
  localparam int DIFF_W = 17;        // Angle change, 0.01 deg units, -360..360 deg
  localparam int MAG_W = 16;         // Magnitude and limit, 0.01 %Un units
  localparam int RAT_W = 16;         // Voltage to limit ratio, 0.01 p.u. units
  localparam int CNT_W = 16;         // Cumulative counters
  localparam int TS_W = 48;          // Millisecond time stamp
  localparam int HIST_N = 12;        // Operation history depth
  localparam int HPTR_W = 4;         // History pointer width
  localparam int GRP_W = 3;          // Setting group 1..8 as 0..7
  localparam int RATIO_SCALE = 100;  // Per-unit scaling to 0.01 p.u.

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int ANGLE_SPAN_MS = 20;   // Angle change is measured over this span
  localparam int PROG_CYCLE_MS = 5;    // Program cycle period
  localparam int SPAN_TICKS = ANGLE_SPAN_MS / PROG_CYCLE_MS;
  localparam int TRIP_HOLD_MS = 20;    // Trip pulse length
  localparam int TRIP_HOLD_CYCLES = TRIP_HOLD_MS * (CLK_HZ / 1000);
  localparam int BLOCK_LEAD_MS = 5;    // Least lead of the block input before the delay ends

  // ==========================================================================
  // Event vector bit positions
  localparam int EV_BLOCK_ON = 0;
  localparam int EV_BLOCK_OFF = 1;
  localparam int EV_TRIP_ON = 2;
  localparam int EV_TRIP_OFF = 3;
  localparam int EV_ALARM_ON = 4;
  localparam int EV_ALARM_OFF = 5;
  localparam int EV_N = 6;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {ST_NORMAL, ST_BLOCKED, ST_TRIP, ST_ALARM} vjss_status_type;
  typedef enum logic [1:0] {EVN_BLOCK, EVN_TRIP, EVN_ALARM} vjss_evname_type;

  // Fault type codes: channel pair L1-L2, L2-L3, L3-L1, or U4
  localparam logic [1:0] FT_U4 = 2'h3;

  typedef struct packed {
    logic [NCH-1:0][ANG_W-1:0] angle;  // Signed present angle per channel
    logic [NCH-1:0][MAG_W-1:0] mag;    // Measured magnitude per channel
  } vjss_meas_type;

  typedef struct packed {
    logic [ANG_W-1:0] trip_pickup;     // Trip angle pick-up, 0.01 deg
    logic [ANG_W-1:0] alarm_pickup;    // Alarm angle pick-up, 0.01 deg
    logic [MAG_W-1:0] uv_limit;        // Undervoltage block limit
    logic alarm_en;                    // 0 trip only, 1 trip and alarm
    logic [NCH-1:0] chan_sel;          // Monitored channels
    logic [GRP_W-1:0] group;           // Active setting group
  } vjss_set_type;

  typedef struct packed {
    logic [TS_W-1:0] stamp;            // Time stamp in ms
    vjss_evname_type name;             // Event name
    logic [1:0] fault;                 // Fault type code
    logic [DIFF_W-1:0] trip_diff;      // Trip angle difference
    logic [DIFF_W-1:0] alarm_diff;     // Alarm angle difference
    logic [GRP_W-1:0] group;           // Setting group in use
  } vjss_hist_type;
endpackage

// ===== testbench/vjss_block_src.sv
// Blocking matrix model: turns a block request of user logic into the stage's block input.
// Assumes the request changes just after a rising edge of the same clock.
`timescale 1ns/100ps

// ============================================================================
// Block source
module vjss_block_src (
  input wire logic CLK,       // Stage clock
  input wire logic RST,       // Async reset, active high
  input wire logic BLOCK_REQ, // Block wanted by user logic
  output logic BLOCK_IN       // Block to the stage
);
  // One register stage, as a matrix output would add; the bench asks two clocks before the sampling edge,
  // far short of the lead time the stage needs before its delay runs out
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      BLOCK_IN <= 1'b0;
    end else begin
      BLOCK_IN <= #1 BLOCK_REQ;
    end
  end
endmodule // vjss_block_src

// ===== testbench/tb.sv
// Self-checking bench for the vector jump supervision stage.
// Assumes short trip and span parameters; the blocking matrix model drives the block input.
`timescale 1ns/100ps

module tb;
  import vjss_pkg::*;
  localparam int TRIPC = 20;
  localparam int SPANT = 2;
  localparam int LIMIT = 5000;
  // ==========================================================================
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic prog_tick = 1'b0;
  logic cnt_clr = 1'b0;
  logic block_req = 1'b0;
  logic block_in, sel_ok, trip_out, alarm_out, blocked_out, evt_valid;
  vjss_meas_type meas;
  vjss_set_type set;
  logic [NCH-1:0] chan_avail = 3'h7;
  logic [EV_N-1:0] evt_mask = 6'h3F;
  logic [EV_N-1:0] evt_vec;
  logic [TS_W-1:0] time_ms = 48'h0;
  logic [TS_W-1:0] evt_stamp;
  logic [HPTR_W-1:0] hist_idx = 4'h0;
  logic [HPTR_W-1:0] hist_count;
  vjss_status_type status;
  logic [NCH-1:0][DIFF_W-1:0] angle_change;
  logic [NCH-1:0][RAT_W-1:0] volt_ratio;
  logic [CNT_W-1:0] cnt_alarm, cnt_trip, cnt_block;
  vjss_hist_type hist_data;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int ang[NCH] = '{0, 0, 0};

  // ==========================================================================
  // Design and far side
  vjss_stage #(.TRIP_CYCLES(TRIPC), .SPAN(SPANT)) u_vjss_stage (.CLK(clk), .RST(rst),
    .PROG_TICK(prog_tick), .BLOCK_IN(block_in), .MEAS(meas), .CHAN_AVAIL(chan_avail),
    .SETTINGS(set), .EVT_MASK(evt_mask), .TIME_MS(time_ms), .CNT_CLR(cnt_clr),
    .HIST_IDX(hist_idx), .STATUS(status), .SEL_OK(sel_ok), .ANGLE_CHANGE(angle_change),
    .VOLT_RATIO(volt_ratio), .TRIP_OUT(trip_out), .ALARM_OUT(alarm_out),
    .BLOCKED_OUT(blocked_out), .EVT_VALID(evt_valid), .EVT_VEC(evt_vec),
    .EVT_STAMP(evt_stamp), .CNT_ALARM(cnt_alarm), .CNT_TRIP(cnt_trip),
    .CNT_BLOCK(cnt_block), .HIST_DATA(hist_data), .HIST_COUNT(hist_count));
  vjss_block_src u_vjss_block_src (.CLK(clk), .RST(rst), .BLOCK_REQ(block_req),
    .BLOCK_IN(block_in));

  // Clock and cycle ceiling; a hang counts as a mismatch
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors = num_errors + 1;
      close_out();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic chk_val(input string name, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic chk_stat(input vjss_status_type exp);
    comparisons++;
    if (status !== exp) begin
      num_errors++;
      $display("FAIL status expected %0d seen %0d", exp, status);
    end
  endtask

  // One program tick; returns just after the sampling edge, so outputs other than HIST_DATA are fresh
  task automatic tick();
    @(posedge clk);
    #1 prog_tick = 1'b1;
    @(posedge clk);
    #1 prog_tick = 1'b0;
  endtask

  // Step one channel's angle by d hundredths of a degree, then tick
  task automatic go(input int ch, input int d);
    ang[ch] += d;
    meas.angle[ch] = ANG_W'(ang[ch]);
    tick();
  endtask

  task automatic close_out();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk_stat(ST_NORMAL);
    chk_val("hist_count", 4'h0, hist_count);
    #1 rst = 1'b0;
  endtask

  // Empty selection and a missing channel are both invalid
  task automatic t_sel();
    set.chan_sel = 3'h0;
    tick();
    chk_val("sel_ok", 1'b0, sel_ok);
    set.chan_sel = 3'h4;
    chan_avail = 3'h3;
    tick();
    chk_val("sel_ok", 1'b0, sel_ok);
    chan_avail = 3'h7;
    set.chan_sel = 3'h3;
    tick();
    chk_val("sel_ok", 1'b1, sel_ok);
    chk_val("ratio", 16'h0069, volt_ratio[0]);
  endtask

  // Jump equal to the pick-up level; the pulse must not retrigger
  task automatic t_trip();
    logic [CNT_W-1:0] n0;
    int t0;
    n0 = cnt_trip;
    time_ms = 48'h123;
    go(0, 500);
    t0 = cyc;
    chk_val("change", 17'h001F4, angle_change[0]);
    chk_val("trip", 1'b1, trip_out);
    chk_stat(ST_TRIP);
    chk_val("evt_valid", 1'b1, evt_valid);
    chk_val("evt_vec", 6'h04, evt_vec);
    chk_val("stamp", 48'h123, evt_stamp);
    chk_val("cnt_trip", n0 + 16'h1, cnt_trip);
    go(0, 0);
    chk_val("cnt_trip", n0 + 16'h1, cnt_trip);
    chk_val("h_name", EVN_TRIP, hist_data.name);
    chk_val("h_trip", 17'h001F4, hist_data.trip_diff);
    chk_val("h_alarm", 17'h0, hist_data.alarm_diff);
    chk_val("h_group", 3'h5, hist_data.group);
    chk_val("h_stamp", 48'h123, hist_data.stamp);
    while (trip_out === 1'b1 && cyc < t0 + 100) begin
      @(posedge clk);
      #1;
    end
    chk_val("trip_len", TRIPC, cyc - t0);
    chk_val("evt_vec", 6'h08, evt_vec);
    chk_stat(ST_NORMAL);
  endtask

  // Block held across a pick-up on the second channel
  task automatic t_block();
    logic [CNT_W-1:0] n0;
    n0 = cnt_block;
    block_req = 1'b1;
    go(1, 600);
    chk_val("blocked", 1'b1, blocked_out);
    chk_val("trip", 1'b0, trip_out);
    chk_stat(ST_BLOCKED);
    chk_val("evt_vec", 6'h01, evt_vec);
    chk_val("cnt_block", n0 + 16'h1, cnt_block);
    go(1, 0);
    chk_val("h_name", EVN_BLOCK, hist_data.name);
    chk_val("h_fault", 2'h1, hist_data.fault);
    go(1, 0);
    chk_val("blocked", 1'b0, blocked_out);
    chk_val("evt_vec", 6'h02, evt_vec);
    block_req = 1'b0;
  endtask

  // Alarm only when enabled; trip level out of reach
  task automatic t_alarm();
    logic [CNT_W-1:0] n0;
    n0 = cnt_alarm;
    set.alarm_en = 1'b1;
    set.trip_pickup = 16'h07D0;
    go(0, 300);
    chk_val("alarm", 1'b1, alarm_out);
    chk_stat(ST_ALARM);
    chk_val("evt_vec", 6'h10, evt_vec);
    chk_val("cnt_alarm", n0 + 16'h1, cnt_alarm);
    go(0, 0);
    go(0, 0);
    chk_val("alarm", 1'b0, alarm_out);
    chk_val("evt_vec", 6'h20, evt_vec);
    set.alarm_en = 1'b0;
    go(0, 300);
    chk_val("alarm", 1'b0, alarm_out);
    chk_stat(ST_NORMAL);
    go(0, 0);
    go(0, 0);
    set.trip_pickup = 16'h01F4;
  endtask

  // Undervoltage at the limit boundary, with only OFF events stored
  task automatic t_uv();
    logic [CNT_W-1:0] n0;
    n0 = cnt_block;
    evt_mask = 6'h2A;
    meas.mag[0] = 16'h251B;
    tick();
    chk_val("ratio", 16'h0063, volt_ratio[0]);
    chk_val("blocked", 1'b1, blocked_out);
    chk_val("evt_valid", 1'b0, evt_valid);
    chk_val("cnt_block", n0 + 16'h1, cnt_block);
    meas.mag[0] = 16'h251C;
    tick();
    chk_val("ratio", 16'h0064, volt_ratio[0]);
    chk_val("blocked", 1'b0, blocked_out);
    chk_val("evt_vec", 6'h02, evt_vec);
    evt_mask = 6'h3F;
  endtask

  // Clear, then thirteen blocked entries to wrap the history
  task automatic t_clr_hist();
    @(posedge clk);
    #1 cnt_clr = 1'b1;
    @(posedge clk);
    #1 cnt_clr = 1'b0;
    chk_val("cnt_all", 48'h0, {cnt_alarm, cnt_trip, cnt_block});
    for (int i = 0; i < 13; i++) begin
      time_ms = TS_W'(48'h100 + i);
      meas.mag[0] = 16'h2328;
      tick();
      meas.mag[0] = 16'h2710;
      tick();
    end
    chk_val("cnt_block", 16'h000D, cnt_block);
    chk_val("hist_count", 4'hC, hist_count);
    chk_val("h_stamp", 48'h10C, hist_data.stamp);
    hist_idx = 4'hB;
    @(posedge clk);
    #1 chk_val("h_stamp", 48'h101, hist_data.stamp);
    hist_idx = 4'hC;
    @(posedge clk);
    #1 chk_val("h_empty", 64'h0, {hist_data.stamp, hist_data.fault, hist_data.name});
    chk_val("h_empty_diff", 64'h0, {hist_data.trip_diff, hist_data.alarm_diff});
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    meas.angle = '0;
    meas.mag = {3{16'h2710}};
    set = '{16'h01F4, 16'h012C, 16'h251C, 1'b0, 3'h3, 3'h5};
    repeat (12) @(posedge clk);
    t_reset();
    t_sel();
    t_trip();
    t_block();
    t_alarm();
    t_uv();
    t_clr_hist();
    close_out();
  end
endmodule // tb
